// *** design/e1i_defs.vh ***
// Constants of the receive E1 alarm and alignment interrupt block
`ifndef E1I_DEFS_VH
`define E1I_DEFS_VH

// Framer channels, each with one status and one enable register
`define E1I_NCH          8
`define E1I_CHW          3
`define E1I_EVW          4
`define E1I_REGW         8
// AXI4-Lite widths
`define E1I_AW           18
`define E1I_DW           32
`define E1I_IDXW         16
// Register indices: byte address is four times the index
`define E1I_STAT_IDX     12'hb12
`define E1I_EN_IDX       12'hb13
`define E1I_SUM_IDX      16'h0f00
// Word index fields: word select, register part, channel part
`define E1I_WORD_LO      2
`define E1I_REG_HI       11
`define E1I_CH_HI        14
`define E1I_CH_LO        12
// Status and enable field positions
`define E1I_BIT_LOS      3
`define E1I_BIT_CRC      2
`define E1I_BIT_CAS      1
`define E1I_BIT_TS16     0
`define E1I_BIT_TS16_ST  4
// Reset values
`define E1I_EV_RST       4'h0
`define E1I_EN_RST       4'h0
// Address decode kinds
`define E1I_KIND_NONE    2'b00
`define E1I_KIND_STAT    2'b01
`define E1I_KIND_EN      2'b10
`define E1I_KIND_SUM     2'b11
// AXI responses
`define E1I_RESP_OKAY    2'b00
`define E1I_RESP_SLVERR  2'b10

`endif

// *** design/e1i_chan.v ***
// One channel's sticky change status, enable gate and interrupt request
`timescale 1ns/1ps
`default_nettype none
`include "e1i_defs.vh"

module e1i_chan (
  // Clock, reset, enable
  input  wire                 i_clk,
  input  wire                 i_arst_n,
  input  wire                 i_ce,
  // Framer conditions {los, crc lock, cas lock, ts16 alarm}
  input  wire [`E1I_EVW-1:0]  i_cond,
  // Register access strobes
  input  wire                 i_rd_clr,
  input  wire                 i_wr_stat,
  input  wire                 i_wr_en,
  input  wire [`E1I_EVW-1:0]  i_wdata,
  // State
  output reg  [`E1I_EVW-1:0]  o_stat_q,
  output reg  [`E1I_EVW-1:0]  o_en_q,
  output reg                  o_irq_q
);

  reg  [`E1I_EVW-1:0] cond_q;
  reg                 primed_q;
  wire [`E1I_EVW-1:0] evt;
  wire [`E1I_EVW-1:0] clr;
  wire [`E1I_EVW-1:0] stat_d;

  // Both edges of each condition are events; first cycle only samples
  assign evt    = (i_cond ^ cond_q) & {`E1I_EVW{primed_q}};
  assign clr    = ({`E1I_EVW{i_rd_clr}} | ({`E1I_EVW{i_wr_stat}} & i_wdata));
  // A new event in the clearing cycle survives
  assign stat_d = (o_stat_q & ~clr) | evt;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cond_q   <= `E1I_EV_RST;
      primed_q <= 1'b0;
      o_stat_q <= `E1I_EV_RST;
      o_en_q   <= `E1I_EN_RST;
      o_irq_q  <= 1'b0;
    end else if (i_ce) begin
      cond_q   <= i_cond;
      primed_q <= 1'b1;
      o_stat_q <= stat_d;
      if (i_wr_en) begin
        o_en_q <= i_wdata;
      end
      // Gate value 0 enables, 1 disables
      o_irq_q  <= |(stat_d & ~o_en_q);
    end
  end

endmodule // e1i_chan

`default_nettype wire

// *** design/e1i_top.v ***
// AXI4-Lite register front end and per-channel interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "e1i_defs.vh"

// How it works
// - Status bit 4 always reads the live timeslot-16 all-ones alarm state.
// - Status bit 3 sets on every rise and fall of loss of signal.
// - Status bit 2 sets when CRC multiframe lock is gained or lost.
// - Status bit 1 sets when CAS multiframe lock is gained or lost.
// - Status bit 0 sets when the timeslot-16 alarm is declared or cleared.
// - Event bits 3..0 stay set until software reads the status register or writes ones to them there.
// - Enable register bits 3..0 gate the events at matching positions.
// - Enable bit 0 means interrupt enabled, 1 means disabled.
// - A recorded event raises an interrupt only when its gate enables it.
module e1i_top (
  // Clock, reset and clock enable
  input  wire                  i_clk,
  input  wire                  i_arst_n,
  input  wire                  i_ce,
  // Framer condition inputs, one bit per channel
  input  wire [`E1I_NCH-1:0]   i_rx_los,
  input  wire [`E1I_NCH-1:0]   i_crc_mf_lock,
  input  wire [`E1I_NCH-1:0]   i_cas_mf_lock,
  input  wire [`E1I_NCH-1:0]   i_ts16_all_ones_state,
  // AXI4-Lite write address
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  input  wire [`E1I_AW-1:0]    s_axi_awaddr,
  input  wire [2:0]            s_axi_awprot,
  // AXI4-Lite write data
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  input  wire [`E1I_DW-1:0]    s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output wire                  s_axi_bvalid,
  input  wire                  s_axi_bready,
  output wire [1:0]            s_axi_bresp,
  // AXI4-Lite read address
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  input  wire [`E1I_AW-1:0]    s_axi_araddr,
  input  wire [2:0]            s_axi_arprot,
  // AXI4-Lite read data
  output wire                  s_axi_rvalid,
  input  wire                  s_axi_rready,
  output wire [`E1I_DW-1:0]    s_axi_rdata,
  output wire [1:0]            s_axi_rresp,
  // Interrupts
  output wire [`E1I_NCH-1:0]   o_ch_irq,
  output wire                  o_irq
);

  // One-hot select of a channel number
  function [`E1I_NCH-1:0] e1i_ch_sel;
    input [`E1I_CHW-1:0] ch;
    begin
      e1i_ch_sel = {{(`E1I_NCH-1){1'b0}}, 1'b1} << ch;
    end
  endfunction

  // Decode a byte address into {kind, channel}
  function [`E1I_CHW+1:0] e1i_decode;
    input [`E1I_AW-1:0] addr;
    reg   [`E1I_IDXW-1:0] idx;
    reg   [`E1I_REG_HI:0] reg_idx;
    reg   [`E1I_CHW-1:0]  ch_idx;
    reg                   ch_space;
    begin
      // Word index, then its register part and its channel part
      idx      = addr[`E1I_AW-1:`E1I_WORD_LO];
      reg_idx  = idx[`E1I_REG_HI:0];
      ch_idx   = idx[`E1I_CH_HI:`E1I_CH_LO];
      // The top index bit lies outside every channel's window
      ch_space = ~idx[`E1I_IDXW-1];
      if (idx == `E1I_SUM_IDX) begin
        e1i_decode = {`E1I_KIND_SUM, {`E1I_CHW{1'b0}}};
      end else if (ch_space && reg_idx == `E1I_STAT_IDX) begin
        e1i_decode = {`E1I_KIND_STAT, ch_idx};
      end else if (ch_space && reg_idx == `E1I_EN_IDX) begin
        e1i_decode = {`E1I_KIND_EN, ch_idx};
      end else begin
        e1i_decode = {`E1I_KIND_NONE, {`E1I_CHW{1'b0}}};
      end
    end
  endfunction

  // Write channel state
  reg                   awready_q;
  reg                   wready_q;
  reg                   aw_held_q;
  reg                   w_held_q;
  reg  [`E1I_AW-1:0]    aw_addr_q;
  reg  [`E1I_DW-1:0]    w_data_q;
  reg  [3:0]            w_strb_q;
  reg                   bvalid_q;
  reg  [1:0]            bresp_q;

  // Read channel state
  reg                   arready_q;
  reg                   rvalid_q;
  reg  [`E1I_DW-1:0]    rdata_q;
  reg  [1:0]            rresp_q;

  // Interrupt outputs
  reg  [`E1I_NCH-1:0]   ch_irq_q;
  reg                   irq_q;

  // Handshakes and decoded accesses
  wire                  aw_hs;
  wire                  w_hs;
  wire                  ar_hs;
  wire                  wr_go;
  wire [`E1I_CHW+1:0]   wr_dec;
  wire [`E1I_CHW+1:0]   rd_dec;
  wire [1:0]            wr_kind;
  wire [`E1I_CHW-1:0]   wr_ch;
  wire [1:0]            rd_kind;
  wire [`E1I_CHW-1:0]   rd_ch;
  wire                  wr_ok;
  wire                  b_hs;
  wire                  r_hs;
  wire                  wr_lane_ok;
  wire                  rd_stat_go;
  wire                  wr_stat_go;
  wire                  wr_en_go;
  wire [`E1I_NCH-1:0]   rd_ch_sel;
  wire [`E1I_NCH-1:0]   wr_ch_sel;

  // Per-channel state, flattened four bits a channel
  wire [`E1I_NCH*`E1I_EVW-1:0] stat_all;
  wire [`E1I_NCH*`E1I_EVW-1:0] en_all;
  wire [`E1I_NCH-1:0]          irq_all;
  wire [`E1I_NCH*`E1I_EVW-1:0] cond_all;

  // Read data selection
  reg  [`E1I_REGW-1:0]  rd_byte;
  reg  [1:0]            rd_resp;
  wire [`E1I_CHW+1:0]   rd_sel;

  assign aw_hs   = s_axi_awvalid & awready_q;
  assign w_hs    = s_axi_wvalid & wready_q;
  assign ar_hs   = s_axi_arvalid & arready_q;
  // Both halves of a write are held before it acts
  assign wr_go   = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_dec  = e1i_decode(aw_addr_q);
  assign rd_dec  = e1i_decode(s_axi_araddr);
  assign wr_kind = wr_dec[`E1I_CHW+1:`E1I_CHW];
  assign wr_ch   = wr_dec[`E1I_CHW-1:0];
  assign rd_kind = rd_dec[`E1I_CHW+1:`E1I_CHW];
  assign rd_ch   = rd_dec[`E1I_CHW-1:0];
  // Only status and enable accept writes
  assign wr_ok   = (wr_kind == `E1I_KIND_STAT) | (wr_kind == `E1I_KIND_EN);
  assign rd_sel  = rd_dec;
  assign b_hs    = bvalid_q & s_axi_bready;
  assign r_hs    = rvalid_q & s_axi_rready;
  // A write with byte lane 0 off is answered but changes nothing
  assign wr_lane_ok = s_axi_bready_ok(w_strb_q);
  assign rd_ch_sel  = e1i_ch_sel(rd_ch);
  assign wr_ch_sel  = e1i_ch_sel(wr_ch);
  // Channel-independent parts of the per-channel strobes
  assign rd_stat_go = ar_hs & (rd_kind == `E1I_KIND_STAT);
  assign wr_stat_go = wr_go & wr_lane_ok & (wr_kind == `E1I_KIND_STAT);
  assign wr_en_go   = wr_go & wr_lane_ok & (wr_kind == `E1I_KIND_EN);

  // One register pair per framer channel
  genvar g;
  generate
    for (g = 0; g < `E1I_NCH; g = g + 1) begin : g_ch
      wire rd_clr;
      wire wr_stat;
      wire wr_en;

      assign cond_all[g*`E1I_EVW+`E1I_BIT_LOS]  = i_rx_los[g];
      assign cond_all[g*`E1I_EVW+`E1I_BIT_CRC]  = i_crc_mf_lock[g];
      assign cond_all[g*`E1I_EVW+`E1I_BIT_CAS]  = i_cas_mf_lock[g];
      assign cond_all[g*`E1I_EVW+`E1I_BIT_TS16] = i_ts16_all_ones_state[g];

      // Accepted status read clears this channel's event bits
      assign rd_clr  = rd_stat_go & rd_ch_sel[g];
      assign wr_stat = wr_stat_go & wr_ch_sel[g];
      assign wr_en   = wr_en_go & wr_ch_sel[g];

      e1i_chan u_chan (
        .i_clk     (i_clk),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_cond    (cond_all[g*`E1I_EVW +: `E1I_EVW]),
        .i_rd_clr  (rd_clr),
        .i_wr_stat (wr_stat),
        .i_wr_en   (wr_en),
        .i_wdata   (w_data_q[`E1I_EVW-1:0]),
        .o_stat_q  (stat_all[g*`E1I_EVW +: `E1I_EVW]),
        .o_en_q    (en_all[g*`E1I_EVW +: `E1I_EVW]),
        .o_irq_q   (irq_all[g])
      );
    end
  endgenerate

  // Low byte lane must be enabled for a register write to act
  function s_axi_bready_ok;
    input [3:0] strb;
    begin
      s_axi_bready_ok = strb[0];
    end
  endfunction

  // Read data for the address on the read address channel
  always @* begin
    rd_byte = {`E1I_REGW{1'b0}};
    rd_resp = `E1I_RESP_OKAY;
    case (rd_sel[`E1I_CHW+1:`E1I_CHW])
      `E1I_KIND_STAT: begin
        rd_byte[`E1I_EVW-1:0]        = stat_all[rd_ch * `E1I_EVW +: `E1I_EVW];
        rd_byte[`E1I_BIT_TS16_ST]    = i_ts16_all_ones_state[rd_ch];
      end
      `E1I_KIND_EN: begin
        rd_byte[`E1I_EVW-1:0]        = en_all[rd_ch * `E1I_EVW +: `E1I_EVW];
      end
      `E1I_KIND_SUM: begin
        rd_byte                      = ch_irq_q;
      end
      default: begin
        rd_resp                      = `E1I_RESP_SLVERR;
      end
    endcase
  end

  // Write address half: held until the write acts, ready again after the response
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
      aw_addr_q <= {`E1I_AW{1'b0}};
    end else if (i_ce) begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end else if (b_hs) begin
        awready_q <= 1'b1;
      end
    end
  end

  // Write data half, taken before, with or after its address
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wready_q  <= 1'b1;
      w_held_q  <= 1'b0;
      w_data_q  <= {`E1I_DW{1'b0}};
      w_strb_q  <= 4'h0;
    end else if (i_ce) begin
      if (w_hs) begin
        wready_q  <= 1'b0;
        w_held_q  <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_strb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q  <= 1'b0;
      end else if (b_hs) begin
        wready_q  <= 1'b1;
      end
    end
  end

  // Response: the readies stay low until it is taken, so one write at a time
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bvalid_q  <= 1'b0;
      bresp_q   <= `E1I_RESP_OKAY;
    end else if (i_ce) begin
      if (wr_go) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? `E1I_RESP_OKAY : `E1I_RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_q  <= 1'b0;
      end
    end
  end

  // Read address: one read outstanding, ready again once the data are taken
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      arready_q <= 1'b1;
    end else if (i_ce) begin
      if (ar_hs) begin
        arready_q <= 1'b0;
      end else if (r_hs) begin
        arready_q <= 1'b1;
      end
    end
  end

  // Read data registered at the address handshake, before any clear lands
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rvalid_q  <= 1'b0;
      rdata_q   <= {`E1I_DW{1'b0}};
      rresp_q   <= `E1I_RESP_OKAY;
    end else if (i_ce) begin
      if (ar_hs) begin
        rvalid_q  <= 1'b1;
        rdata_q   <= {{(`E1I_DW-`E1I_REGW){1'b0}}, rd_byte};
        rresp_q   <= rd_resp;
      end else if (r_hs) begin
        rvalid_q  <= 1'b0;
      end
    end
  end

  // Interrupt outputs, one per channel and one combined level
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ch_irq_q <= {`E1I_NCH{1'b0}};
      irq_q    <= 1'b0;
    end else if (i_ce) begin
      ch_irq_q <= irq_all;
      irq_q    <= |irq_all;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign o_ch_irq      = ch_irq_q;
  assign o_irq         = irq_q;

  // Protection bits carry no meaning here
  wire unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_strb_q[3:1]};

endmodule // e1i_top

`default_nettype wire

// *** dv/e1i_host.sv ***
// Host model: AXI4-Lite master reaching the framer registers
`timescale 1ns/1ps
`default_nettype none
module e1i_host (
  // Clock
  input  wire logic        i_clk,
  // Write
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [17:0] s_axi_awaddr,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic        s_axi_bready,
  input  wire logic        s_axi_bvalid,
  input  wire logic [1:0]  s_axi_bresp,
  // Read
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output var  logic [17:0] s_axi_araddr,
  output var  logic        s_axi_rready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  // Response readies stay high, so no answer is ever stalled
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end
  task automatic wr(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      aw |= s_axi_awready;
      w |= s_axi_wready;
    end
    do @(posedge i_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge i_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge i_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule // e1i_host
`default_nettype wire

// *** dv/e1i_monitor.sv ***
// Assertions on the register port and interrupt outputs
`timescale 1ns/1ps
`default_nettype none
module e1i_monitor (
  // Clock, reset, conditions
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic [7:0]  i_rx_los,
  input wire logic [7:0]  i_crc_mf_lock,
  input wire logic [7:0]  i_cas_mf_lock,
  input wire logic [7:0]  i_ts16_all_ones_state,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Interrupts
  input wire logic [7:0]  o_ch_irq,
  input wire logic        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire [3:0] cond0 = {i_rx_los[0], i_crc_mf_lock[0], i_cas_mf_lock[0], i_ts16_all_ones_state[0]};
  irq_or_a: assert property (o_irq == |o_ch_irq)
    else $error("summary request wrong");
  irq_rise_a: assert property ($rose(o_ch_irq[0]) |->
    $past(cond0, 2) != $past(cond0, 3) || $past(s_axi_bvalid, 2))
    else $error("request rose without cause");
  irq_fall_a: assert property ($fell(o_ch_irq[0]) |->
    $past(s_axi_rvalid) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("request fell without access");
  live_state_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 18'h2c48
    |=> s_axi_rdata[4] == $past(i_ts16_all_ones_state[0]) && s_axi_rdata[31:5] == 27'h0)
    else $error("live alarm bit wrong");
  sum_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 18'h3c00
    |=> s_axi_rdata[7:0] == $past(o_ch_irq) && s_axi_rresp == 2'h0)
    else $error("summary read wrong");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer late");
  wr_excl_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 18'h0
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // e1i_monitor
bind e1i_top e1i_monitor u_e1i_monitor (.i_clk, .i_arst_n, .i_rx_los, .i_crc_mf_lock,
  .i_cas_mf_lock, .i_ts16_all_ones_state, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_rresp, .o_ch_irq, .o_irq);
`default_nettype wire

// *** dv/e1_rx_alarm_align_irq_tb.sv ***
// Self-checking bench for the receive alarm and alignment interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "e1i_defs.vh"
module e1_rx_alarm_align_irq_tb;
  logic i_clk, i_arst_n, i_ce, o_irq;
  logic [7:0] i_rx_los, i_crc_mf_lock, i_cas_mf_lock, i_ts16_all_ones_state, o_ch_irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] st [8], en [8];
  integer mismatches = 0, total_checks = 0, seed = 32'h485515ed, c, k;
  wire [31:0] cv = {i_ts16_all_ones_state, i_cas_mf_lock, i_crc_mf_lock, i_rx_los};
  e1i_top u_e1i_top (.i_clk, .i_arst_n, .i_ce, .i_rx_los, .i_crc_mf_lock, .i_cas_mf_lock,
    .i_ts16_all_ones_state, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .o_ch_irq, .o_irq);
  e1i_host u_e1i_host (.i_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_bready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp);
  initial begin
    i_clk = 0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected channel requests from the model
  function automatic logic [7:0] irqs;
    for (int i = 0; i < 8; i++) irqs[i] = |(st[i] & ~en[i]);
  endfunction
  function automatic logic [17:0] ra(input int ch, input logic [11:0] idx);
    return {1'b0, ch[2:0], idx, 2'b00};
  endfunction
  // Apply framer conditions, record both edges, then check the requests
  task automatic setc(input logic [31:0] v);
    for (int i = 0; i < 8; i++)
      st[i] |= {v[i] ^ cv[i], v[8+i] ^ cv[8+i], v[16+i] ^ cv[16+i], v[24+i] ^ cv[24+i]};
    {i_ts16_all_ones_state, i_cas_mf_lock, i_crc_mf_lock, i_rx_los} <= v;
    repeat (3) @(posedge i_clk);
    chk({o_irq, o_ch_irq}, {|irqs(), irqs()});
  endtask
  task automatic rds(input int ch);
    u_e1i_host.rd(ra(ch, `E1I_STAT_IDX), d, r);
    chk({r, d}, {29'h0, i_ts16_all_ones_state[ch], st[ch]});
    st[ch] = 4'h0;
  endtask
  task automatic wen(input int ch, input logic [3:0] v);
    u_e1i_host.wr(ra(ch, `E1I_EN_IDX), {28'h0, v}, r);
    en[ch] = v;
    u_e1i_host.rd(ra(ch, `E1I_EN_IDX), d, r);
    chk({r, d}, {30'h0, v});
    repeat (2) @(posedge i_clk);
    chk({o_irq, o_ch_irq}, {|irqs(), irqs()});
  endtask
  initial begin
    i_arst_n = 0;
    i_ce = 1'b1;
    {i_ts16_all_ones_state, i_cas_mf_lock, i_crc_mf_lock, i_rx_los} = 32'h0;
    for (c = 0; c < 8; c++) {st[c], en[c]} = 8'h0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    for (c = 0; c < 8; c++) wen(c, 4'h0);
    for (c = 0; c < 8; c++) rds(c);
    c = $unsigned($random(seed)) % 8;
    for (k = 0; k < 8; k++) begin
      setc(cv ^ (32'h1 << (8 * (k % 4) + c)));
      rds(c);
      rds(c);
    end
    for (k = 0; k < 12; k++) begin
      setc($random(seed));
      if (k % 3 == 2) for (c = 0; c < 8; c++) rds(c);
    end
    c = 5;
    for (k = 0; k < 4; k++) begin
      wen(c, 4'hf);
      rds(c);
      setc(cv ^ (32'h1 << (8 * k + c)));
      wen(c, ~(4'h8 >> ((k + 1) % 4)));
      wen(c, ~(4'h8 >> k));
    end
    // Clock enable low freezes all state; the held change lands on release
    i_ce <= 1'b0;
    {i_ts16_all_ones_state, i_cas_mf_lock, i_crc_mf_lock, i_rx_los} <= cv ^ 32'h8;
    repeat (3) @(posedge i_clk);
    chk({o_irq, o_ch_irq}, {|irqs(), irqs()});
    st[3][3] = 1'b1;
    i_ce <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({o_irq, o_ch_irq}, {|irqs(), irqs()});
    u_e1i_host.wr(ra(3, `E1I_STAT_IDX), 32'h8, r);
    st[3] = 4'h0;
    chk(r, `E1I_RESP_OKAY);
    rds(3);
    chk({o_irq, o_ch_irq}, {|irqs(), irqs()});
    wen(c, 4'h0);
    setc(32'h00000081);
    u_e1i_host.rd(18'h3c00, d, r);
    chk({r, d}, {26'h0, irqs()});
    u_e1i_host.rd(18'h0, d, r);
    chk({r, d}, {`E1I_RESP_SLVERR, 32'h0});
    u_e1i_host.wr(18'h3c00, 32'hff, r);
    chk(r, `E1I_RESP_SLVERR);
    end_of_test;
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    mismatches++;
    end_of_test;
  end
endmodule // e1_rx_alarm_align_irq_tb
`default_nettype wire
